/* File: hdl/accum_xfer_wdog_exec.sv */
// executes four single-cycle instructions of a 4-bit cpu core
// assumes one instruction per insn_valid cycle and that the ram read data is
// available one cycle after the address is presented
// Function
// - opcode 213h copies accumulator to timer control six
// - opcode 00Ch copies accumulator into y pointer
// - watchdog restart skips next when flag set, clears
// - swap opcode exchanges accumulator with ram word
// - swap also xors x pointer with immediate
`timescale 1ns/1ps
module accum_xfer_wdog_exec
    import xfer_wdog_pkg::*;
#(
    parameter int AW = RAM_AW
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    input wire logic wdog_disable_op,
    input wire logic [AW-1:0] ram_data_pointer,
    input wire logic wdog_flag_set,
    input wire logic acc_load,
    input wire logic [NIB_W-1:0] acc_load_data,
    output logic [NIB_W-1:0] acc_r,
    output logic [NIB_W-1:0] x_ptr_r,
    output logic [NIB_W-1:0] y_ptr_r,
    output logic [NIB_W-1:0] timer_ctrl_six_r,
    output logic carry_flag_r,
    output logic watchdog_overflow_flag_r,
    output logic watchdog_run_r,
    output logic skip_r
);
    logic acc_to_timer_ctrl6_op;
    logic acc_to_ypointer_op;
    logic watchdog_restart_op;
    logic acc_ram_swap_op;
    logic exec;
    logic prev_disable_r;
    logic [NIB_W-1:0] ram_rdata;
    logic [NIB_W-1:0] imm_j;

    // a skipped word is fetched but not executed
    assign exec = insn_valid && !skip_r;
    assign acc_to_timer_ctrl6_op = exec && (insn == OP_ACC_TO_TIMER_CTRL6);
    assign acc_to_ypointer_op = exec && (insn == OP_ACC_TO_YPOINTER);
    assign watchdog_restart_op = exec && (insn == OP_WATCHDOG_RESTART);
    assign acc_ram_swap_op = exec && (insn[INSN_W-1:SWAP_HI_LSB] == OP_ACC_RAM_SWAP_HI);
    assign imm_j = insn[NIB_W-1:0];

    // ram is read continuously at the pointer; write-back happens on the swap
    nibble_ram #(.AW(AW), .DW(NIB_W)) nibble_ram_i (
        .mclk(mclk),
        .we(acc_ram_swap_op),
        .addr(ram_data_pointer),
        .wdata(acc_r),
        .rdata(ram_rdata)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc_r <= NIB_RESET;
        end else if (acc_ram_swap_op) begin
            acc_r <= ram_rdata;
        end else if (acc_load) begin
            acc_r <= acc_load_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            x_ptr_r <= NIB_RESET;
        end else if (acc_ram_swap_op) begin
            x_ptr_r <= x_ptr_r ^ imm_j;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            y_ptr_r <= NIB_RESET;
        end else if (acc_to_ypointer_op) begin
            y_ptr_r <= acc_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_ctrl_six_r <= NIB_RESET;
        end else if (acc_to_timer_ctrl6_op) begin
            timer_ctrl_six_r <= acc_r;
        end
    end

    // none of these instructions touches carry
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            carry_flag_r <= 1'b0;
        end
    end

    // skip lasts until the next valid word has been discarded
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            skip_r <= 1'b0;
        end else if (watchdog_restart_op && watchdog_overflow_flag_r) begin
            skip_r <= 1'b1;
        end else if (insn_valid) begin
            skip_r <= 1'b0;
        end
    end

    // the flag clears once the skip is done; a new overflow in that cycle wins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            watchdog_overflow_flag_r <= 1'b0;
        end else if (wdog_flag_set) begin
            watchdog_overflow_flag_r <= 1'b1;
        end else if (skip_r && insn_valid) begin
            watchdog_overflow_flag_r <= 1'b0;
        end
    end

    // only an executed disable word arms the stop; a skipped one does not
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_disable_r <= 1'b0;
        end else if (insn_valid) begin
            prev_disable_r <= exec && wdog_disable_op;
        end
    end

    // a stopped watchdog stays stopped until the next reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            watchdog_run_r <= 1'b1;
        end else if (watchdog_restart_op && prev_disable_r) begin
            watchdog_run_r <= 1'b0;
        end
    end

    property p_timer6;
        @(posedge mclk) disable iff (sys_rst)
        acc_to_timer_ctrl6_op |=> timer_ctrl_six_r == $past(acc_r);
    endproperty
    a_timer6: assert property (p_timer6) else $error("timer ctrl six not loaded");

    property p_ypt;
        @(posedge mclk) disable iff (sys_rst)
        acc_to_ypointer_op |=> y_ptr_r == $past(acc_r) && !skip_r;
    endproperty
    a_ypt: assert property (p_ypt) else $error("y pointer not loaded");

    // restart with the flag up arms the skip; the next valid word is then discarded
    sequence s_restart_set;
        watchdog_restart_op && watchdog_overflow_flag_r && !wdog_flag_set;
    endsequence
    sequence s_skip_discard;
        skip_r && insn_valid && !wdog_flag_set;
    endsequence
    property p_watchdog_restart_op;
        @(posedge mclk) disable iff (sys_rst || wdog_flag_set)
        s_restart_set |=> skip_r;
    endproperty
    a_watchdog_restart_op: assert property (p_watchdog_restart_op) else $error("restart did not skip");

    property p_watchdog_restart_op_noskip;
        @(posedge mclk) disable iff (sys_rst)
        watchdog_restart_op && !watchdog_overflow_flag_r |=> !skip_r;
    endproperty
    a_watchdog_restart_op_noskip: assert property (p_watchdog_restart_op_noskip) else $error("spurious skip");

    property p_swap_acc;
        @(posedge mclk) disable iff (sys_rst)
        acc_ram_swap_op |=> acc_r == $past(ram_rdata);
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap acc wrong");

    property p_swap_x;
        @(posedge mclk) disable iff (sys_rst)
        acc_ram_swap_op |=> x_ptr_r == ($past(x_ptr_r) ^ $past(imm_j));
    endproperty
    a_swap_x: assert property (p_swap_x) else $error("x xor wrong");

    property p_carry;
        @(posedge mclk) disable iff (sys_rst)
        exec |=> $stable(carry_flag_r);
    endproperty
    a_carry: assert property (p_carry) else $error("carry changed");

    property p_stop;
        @(posedge mclk) disable iff (sys_rst)
        watchdog_restart_op && prev_disable_r |=> !watchdog_run_r;
    endproperty
    a_stop: assert property (p_stop) else $error("watchdog not stopped");

    property p_skip_clear;
        @(posedge mclk) disable iff (sys_rst)
        s_skip_discard |=> !watchdog_overflow_flag_r && !skip_r;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("flag not cleared after skip");

    // a skipped word must leave the y pointer, timer control six and x pointer alone
    property p_skip_inert;
        @(posedge mclk) disable iff (sys_rst)
        skip_r && insn_valid |=> $stable(y_ptr_r) && $stable(timer_ctrl_six_r) && $stable(x_ptr_r);
    endproperty
    a_skip_inert: assert property (p_skip_inert) else $error("skipped word executed");

    // the overflow pulse must never be lost to a clear in the same cycle
    property p_flag_set_wins;
        @(posedge mclk) disable iff (sys_rst)
        wdog_flag_set |=> watchdog_overflow_flag_r;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("overflow flag lost");

    property p_restart_keeps_run;
        @(posedge mclk) disable iff (sys_rst)
        watchdog_restart_op && !prev_disable_r |=> watchdog_run_r == $past(watchdog_run_r);
    endproperty
    a_restart_keeps_run: assert property (p_restart_keeps_run) else $error("run changed");
endmodule // accum_xfer_wdog_exec

/* File: hdl/nibble_ram.sv */
// small nibble-wide data memory with registered read data
// assumes one write port and one read port on the same clock
`timescale 1ns/1ps
module nibble_ram #(
    parameter int AW = 8,
    parameter int DW = 4
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // nibble_ram

/* File: hdl/xfer_wdog_pkg.sv */
// package for the accumulator transfer / watchdog restart / ram swap decoder
// assumes a 10-bit instruction word and 4-bit data paths
package xfer_wdog_pkg;
    localparam int INSN_W = 10;
    localparam int NIB_W = 4;
    localparam logic [9:0] OP_ACC_TO_TIMER_CTRL6 = 10'h213;
    localparam logic [9:0] OP_ACC_TO_YPOINTER = 10'h00C;
    localparam logic [9:0] OP_WATCHDOG_RESTART = 10'h2A0;
    localparam logic [5:0] OP_ACC_RAM_SWAP_HI = 6'h2D;
    localparam int SWAP_HI_LSB = 4;
    localparam logic [3:0] NIB_RESET = 4'h0;
    localparam int RAM_AW = 8;
endpackage

/* File: sim/tb_accum_xfer_wdog_exec.sv */
// self-checking testbench for the transfer / watchdog restart / swap decoder
// assumes the design package and the ram model are compiled beforehand
`timescale 1ns/1ps
module tb_accum_xfer_wdog_exec;
    import xfer_wdog_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic vld = 1'b0;
    logic dis = 1'b0;
    logic fset = 1'b0;
    logic ld_en = 1'b0;
    logic [9:0] insn = 10'h000;
    logic [3:0] ld_d = 4'h0;
    logic [7:0] dptr = 8'h03;
    logic [3:0] acc, xp, yp, t6, xe;
    logic cflag, wf, run, skp;
    int error_cnt = 0;
    int check_count = 0;

    always #12.5 mclk = ~mclk;

    accum_xfer_wdog_exec accum_xfer_wdog_exec_i (.mclk(mclk), .sys_rst(sys_rst),
        .insn_valid(vld), .insn(insn), .wdog_disable_op(dis), .ram_data_pointer(dptr),
        .wdog_flag_set(fset), .acc_load(ld_en), .acc_load_data(ld_d), .acc_r(acc),
        .x_ptr_r(xp), .y_ptr_r(yp), .timer_ctrl_six_r(t6), .carry_flag_r(cflag),
        .watchdog_overflow_flag_r(wf), .watchdog_run_r(run), .skip_r(skp));

    // one valid word per call; an idle cycle follows so valid never toggles twice at one edge
    task automatic ex(input logic [9:0] w, input logic d = 1'b0);
        @(posedge mclk);
        insn <= w;
        vld <= 1'b1;
        dis <= d;
        @(posedge mclk);
        vld <= 1'b0;
        dis <= 1'b0;
        #1;
    endtask

    task automatic ld(input logic [3:0] v);
        @(posedge mclk);
        ld_en <= 1'b1;
        ld_d <= v;
        @(posedge mclk);
        ld_en <= 1'b0;
        #1;
    endtask

    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        // the ram has no reset: a swap held during reset seeds the word with the cleared acc
        insn <= {OP_ACC_RAM_SWAP_HI, 4'h0};
        vld <= 1'b1;
        repeat (15) @(posedge mclk);
        vld <= 1'b0;
        @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("acc", 4'h0, acc);
        chk("run", 4'h1, {3'h0, run});
        ld(4'h5);
        ex(OP_ACC_TO_TIMER_CTRL6);
        chk("tctl6", 4'h5, t6);
        chk("carry", 4'h0, {3'h0, cflag});
        ld(4'h9);
        ex(OP_ACC_TO_YPOINTER);
        chk("yptr", 4'h9, yp);
        // the word seeded during reset comes back first
        ld(4'hA);
        ex({OP_ACC_RAM_SWAP_HI, 4'h0});
        chk("acc", 4'h0, acc);
        ld(4'h6);
        xe = xp;
        for (int j = 0; j < 16; j++) begin
            ex({OP_ACC_RAM_SWAP_HI, 4'(j)});
            xe = xe ^ 4'(j);
            chk("acc", (j % 2) ? 4'h6 : 4'hA, acc);
            chk("xptr", xe, xp);
        end
        chk("carry", 4'h0, {3'h0, cflag});
        @(posedge mclk);
        fset <= 1'b1;
        @(posedge mclk);
        fset <= 1'b0;
        #1;
        chk("flag", 4'h1, {3'h0, wf});
        ex(OP_WATCHDOG_RESTART);
        chk("skip", 4'h1, {3'h0, skp});
        ex(OP_ACC_TO_YPOINTER);
        chk("yptr", 4'h9, yp);
        chk("flag", 4'h0, {3'h0, wf});
        ex(OP_WATCHDOG_RESTART);
        chk("skip", 4'h0, {3'h0, skp});
        ex(OP_ACC_TO_YPOINTER);
        chk("yptr", 4'h6, yp);
        chk("run", 4'h1, {3'h0, run});
        ex(10'h29C, 1'b1);
        ex(OP_WATCHDOG_RESTART);
        chk("run", 4'h0, {3'h0, run});
        @(posedge mclk);
        fset <= 1'b1;
        @(posedge mclk);
        fset <= 1'b0;
        #1;
        ex(OP_WATCHDOG_RESTART);
        chk("skip", 4'h1, {3'h0, skp});
        // an overflow in the very cycle the skipped word goes by keeps the flag
        @(posedge mclk);
        insn <= OP_ACC_TO_TIMER_CTRL6;
        vld <= 1'b1;
        fset <= 1'b1;
        @(posedge mclk);
        vld <= 1'b0;
        fset <= 1'b0;
        #1;
        chk("flag", 4'h1, {3'h0, wf});
        chk("skip", 4'h0, {3'h0, skp});
        chk("tctl6", 4'h5, t6);
        chk("run", 4'h0, {3'h0, run});
        test_done();
    end

    // the sequence needs well under 200 cycles
    initial begin
        repeat (1000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
endmodule // tb_accum_xfer_wdog_exec
